// ### dv/tb_top.sv
`timescale 1ns/1ps
`include "bpe_consts.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb_top import bpe_pkg::*;;
	localparam logic [31:0] PAT       = 32'hc3a50f96;
	localparam logic [7:0]  RIDX [9]  = '{`BPE_IDX_PAT0, `BPE_IDX_PAT1, `BPE_IDX_PAT2, `BPE_IDX_PAT3,
		`BPE_IDX_EIC, `BPE_IDX_IEN, `BPE_IDX_CNT0, `BPE_IDX_CNT1, `BPE_IDX_LATCH};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, pattern_word;
	logic        tx_line_clock, rx_line_clock, rx_data_pin, tx_data_pin, irq;
	logic        tx_pattern_load, rx_pattern_load, counter_update_request;
	int          failures = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          lc = 0;
	int          bit_idx = 0;
	int          base = 0;
	int          n_err = 0;
	int          last_err = 0;
	int          err_gap = 0;
	int          t;
	logic        armed = 1'b0;
	logic        err;
	bpe_byte_t   rd;
	logic [31:0] exp_sh = 32'h00000000;
	logic        prbs_mode;
	logic [4:0]  prbs_tap;

	// Resync input unused; the checker hunts on its own
	bpe_bert_status #(.PW(32), .CW(24)) dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_line_clock(tx_line_clock), .rx_line_clock(rx_line_clock), .rx_data_pin(rx_data_pin),
		.tx_data_pin(tx_data_pin), .tx_pattern_load(tx_pattern_load), .rx_pattern_load(rx_pattern_load),
		.rx_resync(1'b0), .prbs_mode(prbs_mode), .prbs_tap(prbs_tap),
		.counter_update_request(counter_update_request), .irq(irq), .pattern_word(pattern_word)
	);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Line clocks of 48 ns, rx in antiphase so it samples mid bit; tx looped back
	always @(posedge pclk) begin
		rx_data_pin <= tx_data_pin;
		if (lc == 5) begin
			lc            <= 0;
			tx_line_clock <= ~tx_line_clock;
			rx_line_clock <= tx_line_clock;
		end else begin
			lc <= lc + 1;
		end
	end

	// Tx monitor: generator model reseeded at each load, counts differing bits
	always @(negedge tx_line_clock) begin
		if (bit_idx == base) begin
			exp_sh = PAT;
		end
		if (armed && tx_data_pin !== exp_sh[31]) begin
			n_err++;
			err_gap = bit_idx - last_err;
			last_err = bit_idx;
		end
		exp_sh = {exp_sh[30:0], prbs_mode ? (exp_sh[31] ^ exp_sh[prbs_tap]) : exp_sh[31]};
		bit_idx++;
	end

	// Hang guard, well above the expected run of about 7000 cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 12000) begin
			failures++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (failures == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] idx, input bpe_byte_t wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata[7:0];
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd_chk(input logic [7:0] idx, input bpe_byte_t exp);
		apb(1'b0, idx, 8'h00);
		`CHK(rd, exp)
	endtask

	task automatic wait_err(input int n);
		while (n_err < n) @(posedge pclk);
	endtask

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		tx_line_clock = 1'b0;
		rx_line_clock = 1'b1;
		rx_data_pin = 1'b0;
		tx_pattern_load = 1'b0;
		rx_pattern_load = 1'b0;
		counter_update_request = 1'b0;
		prbs_mode = 1'b0;
		prbs_tap = 5'h00;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, read-only and unmapped places
		foreach (RIDX[i]) rd_chk(RIDX[i], 8'h00);
		apb(1'b1, `BPE_IDX_LIVE, 8'hff);
		rd_chk(`BPE_IDX_LIVE, 8'h01);
		rd_chk(8'h00, 8'h00);
		`CHK(err, 1'b1)
		// Pattern bytes, low byte first
		for (int i = 0; i < 4; i++) apb(1'b1, `BPE_IDX_PAT0 + 8'(i), PAT[8*i +: 8]);
		`CHK(pattern_word, PAT)
		rd_chk(`BPE_IDX_PAT3, 8'hc3);
		apb(1'b1, `BPE_IDX_IEN, 8'h01);
		// Load both ends just after a tx falling edge
		@(negedge tx_line_clock);
		@(posedge pclk);
		base = bit_idx;
		armed = 1'b1;
		tx_pattern_load <= 1'b1;
		rx_pattern_load <= 1'b1;
		@(posedge pclk);
		tx_pattern_load <= 1'b0;
		rx_pattern_load <= 1'b0;
		repeat (64) @(negedge tx_line_clock);
		`CHK(n_err, 0)
		rd = 8'h01;
		while (rd[0] !== 1'b0) apb(1'b0, `BPE_IDX_LIVE, 8'h00);
		`CHK(irq, 1'b1)
		apb(1'b0, `BPE_IDX_LATCH, 8'h00);
		`CHK(rd & 8'h09, 8'h01)
		rd_chk(`BPE_IDX_LATCH, 8'h00);
		`CHK(irq, 1'b0)
		// Single errors: disabled trigger, then three edges in one bit
		apb(1'b1, `BPE_IDX_EIC, 8'h02);
		apb(1'b1, `BPE_IDX_EIC, 8'h00);
		repeat (40) @(negedge tx_line_clock);
		`CHK(n_err, 0)
		apb(1'b1, `BPE_IDX_EIC, 8'h04);
		@(posedge tx_line_clock);
		@(posedge pclk);
		apb(1'b1, `BPE_IDX_EIC, 8'h06);
		apb(1'b1, `BPE_IDX_EIC, 8'h04);
		apb(1'b1, `BPE_IDX_EIC, 8'h06);
		repeat (40) @(negedge tx_line_clock);
		`CHK(n_err, 1)
		apb(1'b1, `BPE_IDX_EIC, 8'h04);
		rd_chk(`BPE_IDX_LIVE, 8'h02);
		`CHK(irq, 1'b0)
		rd_chk(`BPE_IDX_LATCH, 8'h06);
		// Counter update snapshot
		counter_update_request <= 1'b1;
		repeat (4) @(posedge pclk);
		rd_chk(`BPE_IDX_LIVE, 8'h08);
		rd_chk(`BPE_IDX_CNT0, 8'h01);
		rd_chk(`BPE_IDX_CNT1, 8'h00);
		rd_chk(`BPE_IDX_LATCH, 8'h08);
		counter_update_request <= 1'b0;
		@(posedge pclk);
		rd_chk(`BPE_IDX_LIVE, 8'h00);
		// Rate insertion, then a rewrite while it runs
		t = n_err;
		apb(1'b1, `BPE_IDX_EIC, 8'h08);
		wait_err(t + 3);
		`CHK(err_gap, 10)
		wait_err(t + 14);
		apb(1'b0, `BPE_IDX_LIVE, 8'h00);
		`CHK(rd[0], 1'b1)
		apb(1'b0, `BPE_IDX_LATCH, 8'h00);
		`CHK(rd[0], 1'b1)
		apb(1'b1, `BPE_IDX_EIC, 8'h10);
		t = n_err;
		wait_err(t + 1);
		`CHK(err_gap, 10)
		wait_err(t + 2);
		`CHK(err_gap, 100)
		// Zero rate also waits for the pending error, then stops
		apb(1'b1, `BPE_IDX_EIC, 8'h00);
		wait_err(t + 3);
		`CHK(err_gap, 100)
		// Pattern word seeds the PRBS, msb first, no errors after
		@(negedge tx_line_clock);
		@(posedge pclk);
		base = bit_idx;
		prbs_mode <= 1'b1;
		prbs_tap <= 5'd19;
		tx_pattern_load <= 1'b1;
		@(posedge pclk);
		tx_pattern_load <= 1'b0;
		repeat (64) @(negedge tx_line_clock);
		`CHK(n_err, t + 3)
		end_sim();
	end
endmodule

// ### src/bpe_bert_status.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "bpe_consts.svh"
module bpe_bert_status import bpe_pkg::*; #(
	parameter int PW = 32,
	parameter int CW = 24
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial line
	input  wire logic        tx_line_clock,
	input  wire logic        rx_line_clock,
	input  wire logic        rx_data_pin,
	output logic             tx_data_pin,
	// Requests from the rest of the tester
	input  wire logic        tx_pattern_load,
	input  wire logic        rx_pattern_load,
	input  wire logic        rx_resync,
	input  wire logic        prbs_mode,
	input  wire logic [4:0]  prbs_tap,
	input  wire logic        counter_update_request,
	// Interrupt and pattern to the tester
	output logic             irq,
	output logic [PW-1:0]    pattern_word
);
	logic [7:0]    eic;
	logic [3:0]    ien;
	logic [3:0]    latched;
	logic [3:0]    live;
	logic [3:0]    live_d;
	logic [3:0]    rd_clr;
	logic [9:0]    idx;
	logic          mapped;
	logic          wr_acc;
	logic          rd_setup;
	logic          rd_latch;
	logic          rate_wr;
	logic          trig_d;
	logic          single_req;
	logic [2:0]    tx_clk_s;
	logic [2:0]    rx_clk_s;
	logic [1:0]    rx_dat_s;
	logic          tx_bit_en;
	logic          rx_bit_en;
	logic          bit_error;
	logic          unlocked;
	logic [CW-1:0] err_count;
	logic [CW-1:0] err_snap;
	logic          count_inc;
	logic          req_d;
	logic          upd_rise;
	logic          upd_busy;
	logic          done_reg;
	logic          counter_update_done;
	logic          error_count_nonzero;
	logic [31:0]   next_prdata;

	// APB decode; zero-wait slave
	assign idx      = paddr[11:2];
	assign wr_acc   = psel & penable & pwrite & mapped;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_latch = psel & penable & ~pwrite & (idx == {2'b0, `BPE_IDX_LATCH});
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~mapped;

	// Word-aligned known indices only
	always_comb begin
		mapped = 1'b0;
		if (paddr[1:0] == 2'b00) begin
			case (idx[7:0])
				`BPE_IDX_PAT0, `BPE_IDX_PAT1, `BPE_IDX_PAT2, `BPE_IDX_PAT3,
				`BPE_IDX_EIC, `BPE_IDX_LIVE, `BPE_IDX_LATCH, `BPE_IDX_IEN,
				`BPE_IDX_CNT0, `BPE_IDX_CNT1: mapped = (idx[9:8] == 2'b00);
				default: mapped = 1'b0;
			endcase
		end
	end

	// Pattern word bytes, low byte at lowest index
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pattern_word <= {4{`BPE_RST_BYTE}};
		end else if (wr_acc) begin
			case (idx[7:0])
				`BPE_IDX_PAT0: pattern_word[7:0]   <= pwdata[7:0];
				`BPE_IDX_PAT1: pattern_word[15:8]  <= pwdata[7:0];
				`BPE_IDX_PAT2: pattern_word[23:16] <= pwdata[7:0];
				`BPE_IDX_PAT3: pattern_word[31:24] <= pwdata[7:0];
				default: pattern_word <= pattern_word;
			endcase
		end
	end

	// unused bits stored but never acted on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eic <= `BPE_RST_BYTE;
			ien <= `BPE_RST_FLAGS;
		end else if (wr_acc) begin
			if (idx[7:0] == `BPE_IDX_EIC) begin
				eic <= pwdata[7:0];
			end
			if (idx[7:0] == `BPE_IDX_IEN) begin
				ien <= pwdata[3:0];
			end
		end
	end

	// every control write hands the rate to the inserter
	assign rate_wr = wr_acc & (idx[7:0] == `BPE_IDX_EIC);

	// Trigger edge detect on the stored bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_d <= 1'b0;
		end else begin
			trig_d <= eic[`BPE_EIC_TRIG];
		end
	end

	// only a 0 to 1 trigger edge requests
	assign single_req = eic[`BPE_EIC_TRIG] & ~trig_d & eic[`BPE_EIC_SEN];

	// Line clocks and data: two flops before any use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_clk_s <= 3'b000;
			rx_clk_s <= 3'b000;
			rx_dat_s <= 2'b00;
		end else begin
			tx_clk_s <= {tx_clk_s[1:0], tx_line_clock};
			rx_clk_s <= {rx_clk_s[1:0], rx_line_clock};
			rx_dat_s <= {rx_dat_s[0], rx_data_pin};
		end
	end

	// Edges seen from the second stage on; line clock must be well below pclk
	assign tx_bit_en = tx_clk_s[1] & ~tx_clk_s[2];
	assign rx_bit_en = rx_clk_s[1] & ~rx_clk_s[2];

	bpe_tx_insert #(
		.PW(PW),
		.CW(CW)
	) u_tx (
		.pclk        (pclk),
		.presetn     (presetn),
		.bit_en      (tx_bit_en),
		.pattern_word(pattern_word),
		.load        (tx_pattern_load),
		.prbs_mode   (prbs_mode),
		.prbs_tap    (prbs_tap),
		.rate_wr     (rate_wr),
		.rate_new    (pwdata[`BPE_EIC_RATE_HI:`BPE_EIC_RATE_LO]),
		.single_req  (single_req),
		.tx_data     (tx_data_pin)
	);

	bpe_rx_check #(
		.PW(PW)
	) u_rx (
		.pclk        (pclk),
		.presetn     (presetn),
		.bit_en      (rx_bit_en),
		.rx_bit      (rx_dat_s[1]),
		.pattern_word(pattern_word),
		.load        (rx_pattern_load),
		.resync      (rx_resync),
		.bit_error   (bit_error),
		.unlocked    (unlocked)
	);

	// Update request edge
	assign upd_rise = counter_update_request & ~req_d;

	assign count_inc = bit_error & ~unlocked;

	// snapshot then restart, keeping a same-cycle error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_count <= '0;
			err_snap  <= '0;
		end else if (upd_rise) begin
			err_snap  <= err_count;
			err_count <= {{(CW-1){1'b0}}, count_inc};
		end else if (count_inc && err_count != `BPE_CNT_MAX) begin
			err_count <= err_count + CW'(1);
		end
	end

	// Update sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_d    <= 1'b0;
			upd_busy <= 1'b0;
		end else begin
			req_d    <= counter_update_request;
			upd_busy <= upd_rise;
		end
	end

	// done once the snapshot has settled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
		end else if (!counter_update_request || upd_rise) begin
			done_reg <= 1'b0;
		end else if (upd_busy) begin
			done_reg <= 1'b1;
		end
	end

	// request low forces done low without waiting a clock
	assign counter_update_done = done_reg & counter_update_request;
	// nonzero flag, low one cycle while counter restarts
	assign error_count_nonzero = (err_count != '0) & ~upd_busy;

	always_comb begin
		live                = 4'h0;
		live[`BPE_ST_DONE]  = counter_update_done;
		live[`BPE_ST_NZ]    = error_count_nonzero;
		live[`BPE_ST_UNLK]  = unlocked;
	end

	// Previous live status for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_d <= 4'h1; // Checker starts unlocked
		end else begin
			live_d <= live;
		end
	end

	// only bits the reader saw are cleared
	assign rd_clr = rd_latch ? prdata[3:0] : 4'h0;

	// sticky, set wins over read clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched <= `BPE_RST_FLAGS;
		end else begin
			latched <= (latched & ~rd_clr)
				| {live[`BPE_ST_DONE] & ~live_d[`BPE_ST_DONE],
				   bit_error,
				   live[`BPE_ST_NZ] & ~live_d[`BPE_ST_NZ],
				   live[`BPE_ST_UNLK] ^ live_d[`BPE_ST_UNLK]};
		end
	end

	assign irq = |(latched & ien);

	always_comb begin
		next_prdata = 32'h0000_0000;
		case (idx[7:0])
			`BPE_IDX_PAT0:  next_prdata[7:0] = pattern_word[7:0];
			`BPE_IDX_PAT1:  next_prdata[7:0] = pattern_word[15:8];
			`BPE_IDX_PAT2:  next_prdata[7:0] = pattern_word[23:16];
			`BPE_IDX_PAT3:  next_prdata[7:0] = pattern_word[31:24];
			`BPE_IDX_EIC:   next_prdata[7:0] = eic;
			`BPE_IDX_LIVE:  next_prdata[3:0] = live;
			`BPE_IDX_LATCH: next_prdata[3:0] = latched;
			`BPE_IDX_IEN:   next_prdata[3:0] = ien;
			`BPE_IDX_CNT0:  next_prdata[7:0] = err_snap[7:0];
			`BPE_IDX_CNT1:  next_prdata[7:0] = err_snap[15:8];
			default:        next_prdata = 32'h0000_0000;
		endcase
		if (!mapped) begin
			next_prdata = 32'h0000_0000;
		end
	end

	// Read data captured in setup, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_update;
		upd_rise ##1 counter_update_request [*2];
	endsequence

	chk_done_after_upd: assert property (s_update |-> counter_update_done)
		else $error("update done not raised");
	chk_done_drops: assert property (!counter_update_request |-> !counter_update_done)
		else $error("update done high without request");
	chk_snap_copy: assert property (upd_rise |=> err_snap == $past(err_count))
		else $error("snapshot not taken");
	chk_cnt_saturate: assert property (err_count == `BPE_CNT_MAX && !upd_rise |=>
		err_count == `BPE_CNT_MAX)
		else $error("counter wrapped");
	chk_cnt_frozen: assert property (unlocked && !upd_rise |=> $stable(err_count))
		else $error("counter moved while unlocked");
	chk_berr_latch: assert property (bit_error |=> latched[`BPE_ST_BERR])
		else $error("bit error not latched");
	chk_unlk_latch: assert property ($changed(unlocked) |-> ##1 latched[`BPE_ST_UNLK])
		else $error("sync change not latched");
	chk_latch_sticky: assert property (latched[`BPE_ST_NZ] && !rd_latch |=> latched[`BPE_ST_NZ])
		else $error("latched flag lost");
	chk_irq_gate: assert property (latched[`BPE_ST_UNLK] && ien[`BPE_ST_UNLK] |-> irq)
		else $error("enabled flag without interrupt");
	chk_nz_zero: assert property (err_count == '0 |-> !error_count_nonzero)
		else $error("nonzero flag with zero count");
	chk_pat_msb: assert property (wr_acc && idx[7:0] == `BPE_IDX_PAT3 |=>
		pattern_word[31:24] == $past(pwdata[7:0]))
		else $error("pattern byte 3 not written");
endmodule

// ### src/bpe_consts.svh
`ifndef BPE_CONSTS_SVH
`define BPE_CONSTS_SVH
// Register indices; byte address is four times the index
`define BPE_IDX_PAT0   8'h84
`define BPE_IDX_PAT1   8'h85
`define BPE_IDX_PAT2   8'h86
`define BPE_IDX_PAT3   8'h87
`define BPE_IDX_EIC    8'h88
`define BPE_IDX_LIVE   8'h8c
`define BPE_IDX_LATCH  8'h8e
`define BPE_IDX_IEN    8'h90
`define BPE_IDX_CNT0   8'h94
`define BPE_IDX_CNT1   8'h95
// Reset values
`define BPE_RST_BYTE   8'h00
`define BPE_RST_FLAGS  4'h0
// Error insertion control fields
`define BPE_EIC_RATE_LO 3
`define BPE_EIC_RATE_HI 5
`define BPE_EIC_SEN     2
`define BPE_EIC_TRIG    1
// Status bit positions, shared by live, latched and enable
`define BPE_ST_DONE    3
`define BPE_ST_BERR    2
`define BPE_ST_NZ      1
`define BPE_ST_UNLK    0
// Checker counts in line bits and errors, and the error counter maximum
`define BPE_LOCK_RUN   6'd32
`define BPE_WIN_LEN    7'd64
`define BPE_WIN_ERRS   3'd6
`define BPE_CNT_MAX    24'hffffff
`endif

// ### src/bpe_pkg.sv
package bpe_pkg;
	typedef enum logic {BPE_HUNT, BPE_LOCKED} bpe_sync_e;
	typedef logic [7:0] bpe_byte_t;
endpackage

// ### src/bpe_rx_check.sv
`timescale 1ns/1ps
`include "bpe_consts.svh"
module bpe_rx_check import bpe_pkg::*; #(
	parameter int PW = 32
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Received bit and pattern
	input  wire logic          bit_en,
	input  wire logic          rx_bit,
	input  wire logic [PW-1:0] pattern_word,
	input  wire logic          load,
	input  wire logic          resync,
	// Checker results
	output logic               bit_error,
	output logic               unlocked
);
	bpe_sync_e     state;
	logic [PW-1:0] expect_reg;
	logic [5:0]    run;
	logic [6:0]    win;
	logic [2:0]    werr;
	logic          miss;

	// first bit compared to pattern MSB
	assign miss     = rx_bit ^ expect_reg[PW-1];
	assign unlocked = (state == BPE_HUNT);

	// Hunt restarts alignment on every miss; lock drops on error burst
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= BPE_HUNT;
			expect_reg <= '0;
			run        <= 6'd0;
			win        <= 7'd0;
			werr       <= 3'd0;
			bit_error  <= 1'b0;
		end else begin
			bit_error <= 1'b0;
			if (load || resync) begin
				state      <= BPE_HUNT;
				expect_reg <= pattern_word;
				run        <= 6'd0;
			end else if (bit_en) begin
				expect_reg <= {expect_reg[PW-2:0], expect_reg[PW-1]};
				case (state)
					BPE_HUNT: begin
						if (miss) begin
							expect_reg <= pattern_word;
							run        <= 6'd0;
						end else if (run == `BPE_LOCK_RUN - 6'd1) begin
							state <= BPE_LOCKED;
							win   <= 7'd0;
							werr  <= 3'd0;
						end else begin
							run <= run + 6'd1;
						end
					end
					BPE_LOCKED: begin
						bit_error <= miss;
						win       <= (win == `BPE_WIN_LEN - 7'd1) ? 7'd0 : win + 7'd1;
						werr      <= (win == `BPE_WIN_LEN - 7'd1) ? 3'd0 : werr + {2'b0, miss};
						if (miss && werr == `BPE_WIN_ERRS - 3'd1) begin
							state      <= BPE_HUNT;
							expect_reg <= pattern_word;
							run        <= 6'd0;
						end
					end
					default: state <= BPE_HUNT;
				endcase
			end
		end
	end

	chk_err_locked: assert property (@(posedge pclk) disable iff (!presetn)
		bit_error |-> $past(state) == BPE_LOCKED)
		else $error("bit error reported while unlocked");
endmodule

// ### src/bpe_tx_insert.sv
`timescale 1ns/1ps
`include "bpe_consts.svh"
module bpe_tx_insert import bpe_pkg::*; #(
	parameter int PW = 32,
	parameter int CW = 24
) (
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Bit strobe and pattern
	input  wire logic          bit_en,
	input  wire logic [PW-1:0] pattern_word,
	input  wire logic          load,
	input  wire logic          prbs_mode,
	input  wire logic [4:0]    prbs_tap,
	// Error insertion requests
	input  wire logic          rate_wr,
	input  wire logic [2:0]    rate_new,
	input  wire logic          single_req,
	// Line data
	output logic               tx_data
);
	logic [PW-1:0] shreg;
	logic [2:0]    act_rate;
	logic [2:0]    pend_rate;
	logic          pend_valid;
	logic [CW-1:0] rate_cnt;
	logic          single_pend;
	logic          rate_hit;
	logic          gen_bit;

	// One inverted bit in every ten to the power n
	function automatic logic [CW-1:0] period(input logic [2:0] n);
		case (n)
			3'd1: period = CW'(10);
			3'd2: period = CW'(100);
			3'd3: period = CW'(1000);
			3'd4: period = CW'(10000);
			3'd5: period = CW'(100000);
			3'd6: period = CW'(1000000);
			default: period = CW'(10000000);
		endcase
	endfunction

	assign gen_bit = shreg[PW-1];
	// rate hit on last bit of period
	assign rate_hit = (act_rate != 3'd0) && (rate_cnt == period(act_rate) - CW'(1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shreg <= '0;
		end else if (load) begin
			shreg <= pattern_word;
		end else if (bit_en) begin
			shreg <= {shreg[PW-2:0], prbs_mode ? (shreg[PW-1] ^ shreg[prbs_tap]) : shreg[PW-1]};
		end
	end

	// nonzero write starts an idle inserter
	// busy inserter defers new rate past next error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_rate   <= 3'd0;
			pend_rate  <= 3'd0;
			pend_valid <= 1'b0;
			rate_cnt   <= '0;
		end else if (rate_wr && act_rate == 3'd0) begin
			act_rate <= rate_new;
			rate_cnt <= '0;
		end else begin
			if (rate_wr) begin
				pend_rate  <= rate_new;
				pend_valid <= 1'b1;
			end
			if (bit_en && act_rate != 3'd0) begin
				rate_cnt <= rate_hit ? '0 : rate_cnt + CW'(1);
				if (rate_hit && pend_valid && !rate_wr) begin
					act_rate   <= pend_rate;
					pend_valid <= 1'b0;
				end
			end
		end
	end

	// many requests before one bit give one error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			single_pend <= 1'b0;
		end else if (single_req) begin
			single_pend <= 1'b1; // Set wins over the consuming bit
		end else if (bit_en && !rate_hit) begin
			single_pend <= 1'b0; // A rate error in this bit holds it for the next
		end
	end

	// pending single error flips one bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_data <= 1'b0;
		end else if (bit_en) begin
			tx_data <= gen_bit ^ rate_hit ^ (single_pend & ~rate_hit);
		end
	end

	chk_single_flip: assert property (@(posedge pclk) disable iff (!presetn)
		bit_en && single_pend && !rate_hit |=> tx_data != $past(gen_bit))
		else $error("single error not inserted");
	chk_single_kept: assert property (@(posedge pclk) disable iff (!presetn)
		bit_en && single_pend && rate_hit |=> single_pend)
		else $error("single error lost under rate error");
	chk_rate_bound: assert property (@(posedge pclk) disable iff (!presetn)
		act_rate != 3'd0 |-> rate_cnt < period(act_rate))
		else $error("rate counter past its period");
endmodule
